// >>> core/sadc_readout.sv
`timescale 1ns/1ns
// ****************************************************************
// Serial readout and conversion framing of a SAR converter.
// ****************************************************************
// The link logic runs on the host serial clock and frame select; the system
// side receives finished results through a toggle crossing and link activity as a synchronised level.

module sadc_readout
#(
   parameter int unsigned RES_BITS = 12
)
(
   // System clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Serial link pins.
   input wire logic sclk,
   input wire logic cs_n,
   output logic serial_result_out,
   output logic serial_result_oe_n,
   // Analog core: trial code and comparator decision.
   output logic [RES_BITS-1:0] dac_code,
   input wire logic cmp_above,
   output logic sample_hold,
   // System side results.
   output sadc_pkg::sadc_result_t result,
   output logic result_valid,
   output logic link_busy
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Only the two documented resolutions fit the word layout.
   if (RES_BITS != 12 && RES_BITS != 10)
   begin : g_bad_res
      $error("RES_BITS must be 12 or 10");
   end

   // ****************************************************************
   // Link domain, falling edges: counter, output bit, delivery
   // ****************************************************************
   // Falling edges seen in the frame; zero means idle.
   logic [3:0] count_reg, count_next;
   // Bit presented on the serial output.
   logic sdo_reg, sdo_next;
   // Frame select rose before the word was complete.
   logic abort_reg, abort_next;
   // Word finished while frame select is still low.
   logic done_reg, done_next;
   // Completed result held steady for the crossing.
   logic [RES_BITS-1:0] hold_reg, hold_next;
   // Toggles once per completed, unaborted conversion.
   logic tog_reg, tog_next;
   // Successive approximation register, rising edge domain.
   logic [RES_BITS-1:0] sar_reg, sar_next;
   // Sixteen-bit serial word built from the approximation.
   logic [sadc_pkg::WORD_BITS-1:0] word;
   logic [sadc_pkg::FIELD_BITS-1:0] field;

   // Data field is MSB aligned, so a 10-bit result gets two
   // trailing zeros for free.
   always_comb
   begin
      field = sadc_pkg::FIELD_BITS'({sar_reg,
         {(sadc_pkg::FIELD_BITS - RES_BITS + 1){1'b0}}} >> 1);
      word = {{sadc_pkg::LEAD_ZEROS{1'b0}}, field};
   end

   // Next falling edge state. The counter runs on once started so
   // that an aborted frame still releases the line on edge 16.
   always_comb
   begin
      count_next = count_reg;
      abort_next = abort_reg;
      done_next = done_reg;
      hold_next = hold_reg;
      tog_next = tog_reg;
      if (count_reg == sadc_pkg::CNT_IDLE)
      begin
         // A low frame select with no finished word starts counting.
         if (!cs_n && !done_reg)
         begin
            count_next = 4'h1;
            abort_next = 1'b0;
         end
      end
      else
      begin
         count_next = 4'(count_reg + 4'h1);
         if (cs_n)
         begin
            abort_next = 1'b1;
         end
         if (count_reg == sadc_pkg::LAST_EDGE)
         begin
            // Sixteenth edge: release and deliver unless aborted.
            done_next = 1'b1;
            if (!abort_reg && !cs_n)
            begin
               hold_next = sar_reg;
               tog_next = ~tog_reg;
            end
         end
      end
      // The word bit for the new count; count zero gives a zero.
      sdo_next = word[4'(sadc_pkg::LAST_EDGE - count_next)];
   end

   // Falling edge registers; done clears as soon as frame select
   // goes high so a new frame can drive before any serial edge.
   always_ff @(negedge sclk or posedge srst)
   begin
      if (srst)
      begin
         count_reg <= sadc_pkg::CNT_IDLE;
         sdo_reg <= 1'b0;
         abort_reg <= 1'b0;
         hold_reg <= '0;
         tog_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         sdo_reg <= sdo_next;
         abort_reg <= abort_next;
         hold_reg <= hold_next;
         tog_reg <= tog_next;
      end
   end

   // The finished flag alone is also cleared by frame select high.
   always_ff @(negedge sclk or posedge srst or posedge cs_n)
   begin
      if (srst || cs_n)
      begin
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= done_next;
      end
   end

   // Drive from the frame select edge until edge 16.
   assign serial_result_oe_n = !((!cs_n && !done_reg) ||
      (count_reg != sadc_pkg::CNT_IDLE));
   assign serial_result_out = sdo_reg;

   // ****************************************************************
   // Link domain, rising edges: track/hold and approximation
   // ****************************************************************
   // Sampler is back in track mode.
   logic track_reg, track_next;
   // Bit under trial this rising edge, one-hot.
   logic [RES_BITS-1:0] trial;

   // One bit is resolved per rising edge from edge 2 on, so the
   // MSB is ready well before it is shifted out on falling edge 4.
   always_comb
   begin
      trial = '0;
      sar_next = sar_reg;
      track_next = !(count_reg != sadc_pkg::CNT_IDLE &&
         count_reg < sadc_pkg::TRACK_EDGE);
      if (count_reg == sadc_pkg::SAR_CLEAR)
      begin
         sar_next = '0;
      end
      else if (count_reg >= sadc_pkg::SAR_FIRST && !abort_reg &&
         count_reg < 4'(sadc_pkg::SAR_FIRST + RES_BITS))
      begin
         trial = RES_BITS'(1) << (RES_BITS - 1 -
            int'(count_reg - sadc_pkg::SAR_FIRST));
         sar_next = cmp_above ? (sar_reg | trial) : sar_reg;
      end
   end

   // Rising edge registers.
   always_ff @(posedge sclk or posedge srst)
   begin
      if (srst)
      begin
         sar_reg <= '0;
         track_reg <= 1'b1;
      end
      else
      begin
         sar_reg <= sar_next;
         track_reg <= track_next;
      end
   end

   // Hold until rising edge 13; track_reg is stale before edge 1.
   assign sample_hold = (!cs_n && !done_reg &&
      count_reg == sadc_pkg::CNT_IDLE) || (count_reg != sadc_pkg::CNT_IDLE &&
      (count_reg < sadc_pkg::TRACK_EDGE || !track_reg));
   assign dac_code = sar_reg | trial;

   // ****************************************************************
   // System domain: result capture
   // ****************************************************************
   // Synchronised delivery toggle and frame activity.
   logic tog_sync, busy_sync;
   // Last toggle value seen, for edge detection.
   logic tog_seen_reg, tog_seen_next;
   sadc_pkg::sadc_result_t result_reg, result_next;
   logic valid_reg, valid_next;

   sadc_sync #(.WIDTH(2)) u_sync
   (
      .clock(clock),
      .srst(srst),
      .async_in({tog_reg, !serial_result_oe_n}),
      .sync_out({tog_sync, busy_sync})
   );

   // The held word is stable for a whole frame after each toggle,
   // far longer than the two-stage crossing takes.
   always_comb
   begin
      tog_seen_next = tog_sync;
      valid_next = tog_sync != tog_seen_reg;
      result_next = result_reg;
      if (tog_sync != tog_seen_reg)
      begin
         result_next.code = sadc_pkg::FIELD_BITS'({hold_reg,
            {(sadc_pkg::FIELD_BITS - RES_BITS + 1){1'b0}}} >> 1);
         result_next.width10 = (RES_BITS == 10);
      end
      if (srst)
      begin
         tog_seen_next = 1'b0;
         valid_next = 1'b0;
         result_next = '0;
      end
   end

   // System registers.
   always_ff @(posedge clock)
   begin
      tog_seen_reg <= tog_seen_next;
      valid_reg <= valid_next;
      result_reg <= result_next;
   end

   assign result = result_reg;
   assign result_valid = valid_reg;
   assign link_busy = busy_sync;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Release is seen on the rising edge after falling edge 16, since
   // the next falling edge may already belong to a new frame.
   a_release_sixteen: assert property (@(posedge sclk)
      disable iff (srst) count_reg == sadc_pkg::LAST_EDGE |=>
      serial_result_oe_n) else $error("line not released on edge sixteen");
   a_drive_running: assert property (@(negedge sclk)
      disable iff (srst) count_reg inside {[4'h1:4'hE]} |=>
      !serial_result_oe_n) else $error("line released before edge sixteen");
   a_count_steps: assert property (@(negedge sclk)
      disable iff (srst) count_reg != sadc_pkg::CNT_IDLE |=>
      count_reg == 4'($past(count_reg) + 4'h1)) else $error("counter skipped");
   a_first_zero: assert property (@(negedge sclk) disable iff (srst)
      !cs_n && !done_reg && count_reg == sadc_pkg::CNT_IDLE |->
      !serial_result_oe_n && !serial_result_out) else $error("no first zero");
   a_lead_zeros: assert property (@(negedge sclk) disable iff (srst)
      count_reg inside {4'h1, 4'h2, 4'h3} |-> !serial_result_out)
      else $error("leading zero missing");
   a_trail_zeros: assert property (@(negedge sclk) disable iff (srst)
      RES_BITS == 10 && count_reg inside {4'hE, 4'hF} |-> !serial_result_out)
      else $error("trailing zero missing");
   a_msb_first: assert property (@(negedge sclk) disable iff (srst)
      count_reg == 4'h4 |-> serial_result_out == sar_reg[RES_BITS-1])
      else $error("msb not first");
   a_track_return: assert property (@(posedge sclk) disable iff (srst)
      count_reg == sadc_pkg::TRACK_EDGE |-> !track_reg ##1 track_reg)
      else $error("track not resumed on edge thirteen");
   a_hold_window: assert property (@(posedge sclk) disable iff (srst)
      count_reg inside {[4'h1:4'hC]} |-> sample_hold)
      else $error("sampler left hold early");
   a_valid_pulse: assert property (@(posedge clock) disable iff (srst)
      result_valid |=> !result_valid) else $error("result valid too long");
endmodule

// >>> core/sadc_sync.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-stage level synchroniser into the system clock domain.
// ****************************************************************
module sadc_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   // Destination clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Level from the other domain and its synchronised copy.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // First stage, read only by the second stage.
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   // Second stage, safe for any logic to read.
   logic [WIDTH-1:0] stable_reg;
   logic [WIDTH-1:0] stable_next;

   // Next values: both stages clear under reset.
   always_comb
   begin
      meta_next = srst ? '0 : async_in;
      stable_next = srst ? '0 : meta_reg;
   end

   // The stages only register their next values.
   always_ff @(posedge clock)
   begin
      meta_reg <= meta_next;
      stable_reg <= stable_next;
   end

   assign sync_out = stable_reg;

endmodule

// >>> pkg/sadc_pkg.sv
// ****************************************************************
// Shared constants and types of the serial converter readout.
// ****************************************************************
package sadc_pkg;

   // Serial word length in link clock cycles.
   localparam int unsigned WORD_BITS = 16;
   // Number of zero bits that open every word.
   localparam int unsigned LEAD_ZEROS = 4;
   // Widest result that the data field of the word can carry.
   localparam int unsigned FIELD_BITS = 12;
   // Rising edge on which the sampling circuit returns to track.
   localparam logic [3:0] TRACK_EDGE = 4'hD;
   // Edge count of the last data bit before the word wraps.
   localparam logic [3:0] LAST_EDGE = 4'hF;
   // Idle value of the edge counter.
   localparam logic [3:0] CNT_IDLE = 4'h0;
   // Edge count on which the successive approximation is cleared.
   localparam logic [3:0] SAR_CLEAR = 4'h1;
   // Edge count on which the first result bit is resolved.
   localparam logic [3:0] SAR_FIRST = 4'h2;

   // Result word handed to the system side.
   typedef struct packed
   {
      logic [FIELD_BITS-1:0] code;
      logic width10;
   } sadc_result_t;

endpackage

// >>> verification/sadc_host.sv
`timescale 1ns/1ns
// ****************************************
// Host serial port model.
// ****************************************
module sadc_host
(
   // Serial clock and frame select.
   output logic sclk,
   output logic cs_n,
   // Data pins of both converters.
   input wire logic sdo12,
   input wire logic oe12_n,
   input wire logic sdo10,
   input wire logic oe10_n,
   // Sampler state of the 12-bit part.
   input wire logic hold
);
   logic line12; // Resolved 12-bit data wire.
   logic line10; // Resolved 10-bit data wire.

   // A released wire shows the inverse, so a stale bit never passes.
   always_comb
   begin
      line12 = oe12_n ? ~sdo12 : sdo12;
      line10 = oe10_n ? ~sdo10 : sdo10;
   end

   // Clock idles high and stands still outside frames.
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
   end

   // One frame of 16 cycles; abort_at gives the fall that ends it early.
   task automatic frame(input int abort_at, output logic [15:0] w12,
      output logic [15:0] w10, output logic [1:0] hs,
      output logic [1:0] oe);
      cs_n = 1'b0;
      #10;
      oe[1] = oe12_n | oe10_n;
      for (int i = 1; i <= 16; i++)
      begin
         // The bit ahead of a fall is read just before that fall.
         w12[16-i] = line12;
         w10[16-i] = line10;
         sclk = 1'b0;
         #7;
         if (i == abort_at)
         begin
            cs_n = 1'b1;
         end
         sclk = 1'b1;
         #8;
         if (i == 12)
         begin
            hs[1] = hold;
         end
         if (i == 13)
         begin
            hs[0] = hold;
         end
      end
      oe[0] = oe12_n & oe10_n;
      cs_n = 1'b1;
      #30;
   endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
// ****************************************
// Bench for the converter readout.
// ****************************************
module tb_top;
   logic clock, srst, sclk, cs_n;
   logic sdo12, oe12_n, sdo10, oe10_n, hold12, val12, val10;
   logic [11:0] vin; // Analog input as a code.
   logic [11:0] dac12;
   logic [9:0] dac10;
   sadc_pkg::sadc_result_t res12, res10, exp_q[$], exp10_q[$];
   int fail_count, tests_run;
   logic [15:0] w12, w10;
   logic [1:0] hs, oe;
   logic [11:0] v;
   sadc_pkg::sadc_result_t exp_r; // Oldest note, taken off once.
   logic busy12, busy10; // Link activity seen by the system side.

   // Comparators of both analog cores follow the trial codes at once.
   wire cmp12 = vin >= dac12;
   wire cmp10 = vin[11:2] >= dac10;

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   sadc_host host (.sclk(sclk), .cs_n(cs_n), .sdo12(sdo12),
      .oe12_n(oe12_n), .sdo10(sdo10), .oe10_n(oe10_n), .hold(hold12));

   sadc_readout #(.RES_BITS(12)) DUT (.clock(clock), .srst(srst),
      .sclk(sclk), .cs_n(cs_n), .serial_result_out(sdo12),
      .serial_result_oe_n(oe12_n), .dac_code(dac12), .cmp_above(cmp12),
      .sample_hold(hold12), .result(res12), .result_valid(val12),
      .link_busy(busy12));

   sadc_readout #(.RES_BITS(10)) DUT10 (.clock(clock), .srst(srst),
      .sclk(sclk), .cs_n(cs_n), .serial_result_out(sdo10),
      .serial_result_oe_n(oe10_n), .dac_code(dac10), .cmp_above(cmp10),
      .sample_hold(), .result(res10), .result_valid(val10),
      .link_busy(busy10));

   // Watcher: each result takes the oldest note; a spare one is an error.
   always @(posedge clock)
   begin
      if (!srst && val12 === 1'b1)
      begin
         `CHK(exp_q.size() > 0, 1'b1)
         if (exp_q.size() > 0)
         begin
            exp_r = exp_q.pop_front();
            `CHK(res12, exp_r)
         end
      end
      if (!srst && val10 === 1'b1)
      begin
         `CHK(exp10_q.size() > 0, 1'b1)
         if (exp10_q.size() > 0)
         begin
            exp_r = exp10_q.pop_front();
            `CHK(res10, exp_r)
         end
      end
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One frame with a given input; abort_at of zero runs it whole.
   task automatic run(input logic [11:0] val, input int abort_at);
      @(posedge clock) vin <= val;
      @(posedge clock);
      if (abort_at == 0)
      begin
         exp_q.push_back(sadc_pkg::sadc_result_t'{code: val, width10: 1'b0});
         exp10_q.push_back(sadc_pkg::sadc_result_t'{
            code: {val[11:2], 2'h0}, width10: 1'b1});
      end
      // Mid-frame, both lines are driven and the activity has crossed.
      fork
         host.frame(abort_at, w12, w10, hs, oe);
         begin
            repeat (6) @(posedge clock);
            `CHK({busy12, busy10}, 2'h3)
         end
      join
      `CHK(oe, 2'h1)
      if (abort_at == 0)
      begin
         `CHK(w12, {4'h0, val})
         `CHK(w10, {4'h0, val[11:2], 2'h0})
         `CHK(hs, 2'h2)
      end
      repeat (8) @(posedge clock);
      `CHK({busy12, busy10}, 2'h0)
   endtask

   // Main sequence: edge codes, random codes, an abort, then recovery.
   initial
   begin
      srst = 1'b1;
      vin = 12'h000;
      fail_count = 0;
      tests_run = 0;
      void'($urandom(15));
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      run(12'h000, 0);
      run(12'hFFF, 0);
      run(12'h800, 0);
      for (int k = 0; k < 6; k++)
      begin
         v = 12'($urandom);
         run(v, 0);
      end
      run(12'hA5A, 8);
      run(12'h7FF, 0);
      `CHK(exp_q.size() + exp10_q.size(), 0)
      give_verdict();
   end

   // Whole run needs a few microseconds.
   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end
endmodule
